/* File: hdl/fr_atm_iwf_pkg.sv */
// Constants, carrier structs and CRC helper for the frame/cell interworking
package fr_atm_iwf_pkg;
  localparam int CONN_W = 2;
  localparam int NCONN = 4;
  localparam int VC_W = 8;
  localparam int CNT_W = 16;
  // Register byte addresses
  localparam logic [7:0] REG_TX_FRAMES = 8'h00;
  localparam logic [7:0] REG_RX_FRAMES = 8'h04;
  localparam logic [7:0] REG_RX_CRC_ERR = 8'h08;
  localparam logic [7:0] REG_RX_DROP = 8'h0C;
  localparam logic [7:0] REG_CONN_BASE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Header octet 1 field positions
  localparam int HDR_DE_BIT = 1;
  localparam int HDR_FECN_BIT = 3;
  localparam logic [7:0] HDR_DE_MASK = 8'h02;
  localparam logic [7:0] HDR_FECN_MASK = 8'h08;
  // Cell and trailer geometry
  localparam logic [5:0] CELL_LAST_POS = 6'h2F;
  localparam logic [5:0] TRAIL_START = 6'h28;
  localparam logic [16:0] TRAIL_LEN = 17'h00008;
  localparam logic [16:0] CELL_LEN = 17'h00030;
  localparam logic [16:0] HDR_MIN = 17'h00002;
  // CRC-32 of the common part trailer
  localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC32_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC32_RESIDUE = 32'hC704DD7B;

  typedef enum logic [2:0] {
    TX_DATA = 3'h1, TX_PAD = 3'h2, TX_TRAIL = 3'h4
  } tx_state_type;
  typedef enum logic [1:0] {RX_RECV = 2'h1, RX_PLAY = 2'h2} rx_state_type;

  // Per-connection setup word, top bit downward
  typedef struct packed {
    logic [VC_W-1:0] vc;
    logic [9:0] dlci;
    logic mux;
    logic rx_clp_ignore;
    logic clp_value;
    logic tx_clp_const;
  } conn_cfg_type;
  localparam int CFG_W = $bits(conn_cfg_type);

  typedef struct packed {
    logic [7:0] data;
    logic cell_end;
    logic uu;
    logic clp;
    logic efci;
    logic [VC_W-1:0] vc;
  } cell_beat_type;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic [CONN_W-1:0] conn;
  } frame_beat_type;

  // One octet into the CRC, most significant bit first
  function automatic logic [31:0] crc32_byte(input logic [31:0] c,
                                             input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ CRC32_POLY) : {r[30:0], 1'b0};
    end
    return r;
  endfunction : crc32_byte
endpackage : fr_atm_iwf_pkg

/* File: hdl/fr_atm_iwf.sv */
// Frame/cell interworking core: framing, CRC, DE/CLP and FECN/EFCI mapping
//
// Overview of operation
// - PDU is the core frame minus FCS; flags and stuffing removed upstream.
// - Two-octet address header is always handled in both directions.
// - Three and four octet headers are also accepted and passed through.
// - Trailer ends the last cell, which carries the user-to-user mark.
// - CRC-32 appended on segmentation and checked on reassembly.
// - Each connection may own its virtual channel, selected per connection.
// - Optional sharing of a channel, told apart by the connection identifier.
// - Mode one copies the frame DE bit into CLP of every cell.
// - Mode two sends every cell with a fixed configured CLP value.
// - Receive mode one sets DE when any cell had CLP or header DE.
// - Receive mode two passes header DE unchanged, ignoring CLP.
// - FECN passes unchanged in the header; cell EFCI is always zero.
// - Outgoing FECN set when last cell EFCI or header FECN was set.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module fr_atm_iwf #(
  parameter int MAX_PDU = 2048
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Frames in, toward cells
  input wire fr_atm_iwf_pkg::frame_beat_type fr_in,
  input wire logic fr_in_valid,
  output logic fr_in_ready,
  // Cells out
  output fr_atm_iwf_pkg::cell_beat_type cell_out,
  output logic cell_out_valid,
  input wire logic cell_out_ready,
  // Cells in
  input wire fr_atm_iwf_pkg::cell_beat_type cell_in,
  input wire logic cell_in_valid,
  output logic cell_in_ready,
  // Frames out, toward frame side
  output fr_atm_iwf_pkg::frame_beat_type fr_out,
  output logic fr_out_valid,
  input wire logic fr_out_ready
);
  localparam int AW = $clog2(MAX_PDU);
  localparam logic [16:0] MAX_LEN = 17'(MAX_PDU);

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    fr_atm_iwf_pkg::conn_cfg_type [fr_atm_iwf_pkg::NCONN-1:0] cfg;
    fr_atm_iwf_pkg::tx_state_type tx_st;
    logic [1:0] held;
    logic [1:0] in_cnt;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [15:0] tx_len;
    logic [5:0] pos;
    logic [2:0] tidx;
    logic [31:0] tx_crc;
    logic tx_de;
    fr_atm_iwf_pkg::conn_cfg_type tx_cfg;
    fr_atm_iwf_pkg::rx_state_type rx_st;
    logic [16:0] wcnt;
    logic [31:0] rx_crc;
    logic [63:0] sh;
    logic clp_any;
    logic [7:0] hdr0;
    logic [7:0] hdr1;
    logic [fr_atm_iwf_pkg::VC_W-1:0] rx_vc;
    logic [fr_atm_iwf_pkg::CONN_W-1:0] rx_conn;
    logic rx_ignore;
    logic de_add;
    logic fecn_add;
    logic [15:0] rlen;
    logic [15:0] oidx;
    logic [7:0] obyte;
    logic [fr_atm_iwf_pkg::CNT_W-1:0] tx_frames;
    logic [fr_atm_iwf_pkg::CNT_W-1:0] rx_frames;
    logic [fr_atm_iwf_pkg::CNT_W-1:0] crc_err;
    logic [fr_atm_iwf_pkg::CNT_W-1:0] drops;
  } state_type;

  state_type s;
  state_type next_s;
  logic [7:0] rx_mem [MAX_PDU];
  logic mem_we;
  logic [15:0] rd_idx;
  logic [7:0] rd_raw;
  logic tx_acc;
  logic rx_acc;
  logic rx_crc_ok;
  logic rx_hit;

  // Cell position after one more octet
  function automatic logic [5:0] pos_inc(input logic [5:0] p);
    return (p == fr_atm_iwf_pkg::CELL_LAST_POS) ? 6'h00 : p + 6'h01;
  endfunction : pos_inc

  // Register map decode: {connection hit, connection index}
  function automatic logic [fr_atm_iwf_pkg::CONN_W:0] conn_decode(
      input logic [7:0] a);
    logic [7:0] off;
    off = a - fr_atm_iwf_pkg::REG_CONN_BASE;
    if (a >= fr_atm_iwf_pkg::REG_CONN_BASE &&
        off[7:2] < 6'(fr_atm_iwf_pkg::NCONN)) begin
      return {1'b1, off[fr_atm_iwf_pkg::CONN_W+1:2]};
    end
    return '0;
  endfunction : conn_decode

  function automatic state_type reset_value();
    state_type r;
    r = '0;
    r.tx_st = fr_atm_iwf_pkg::TX_DATA;
    r.rx_st = fr_atm_iwf_pkg::RX_RECV;
    r.tx_crc = fr_atm_iwf_pkg::CRC32_INIT;
    r.rx_crc = fr_atm_iwf_pkg::CRC32_INIT;
    // One channel per connection out of reset
    for (int i = 0; i < fr_atm_iwf_pkg::NCONN; i++) begin
      r.cfg[i].vc = fr_atm_iwf_pkg::VC_W'(i);
    end
    return r;
  endfunction : reset_value

  // Handshakes; frame input stalls while pad and trailer go out
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign fr_in_ready = (s.tx_st == fr_atm_iwf_pkg::TX_DATA) &&
                       (s.held != 2'h2 || cell_out_ready);
  assign tx_acc = fr_in_valid && fr_in_ready;
  assign cell_in_ready = (s.rx_st == fr_atm_iwf_pkg::RX_RECV);
  assign rx_acc = cell_in_valid && cell_in_ready;

  // Oldest held octet leaves only once a later one proves it is not FCS
  assign cell_out_valid = (s.tx_st != fr_atm_iwf_pkg::TX_DATA) ||
                          (s.held == 2'h2 && fr_in_valid);
  assign cell_out.data = s.p0;
  assign cell_out.cell_end = (s.pos == fr_atm_iwf_pkg::CELL_LAST_POS);
  assign cell_out.uu = (s.tx_st == fr_atm_iwf_pkg::TX_TRAIL) &&
                       (s.tidx == 3'h7);
  assign cell_out.clp = s.tx_cfg.tx_clp_const ? s.tx_cfg.clp_value
                                              : s.tx_de;
  assign cell_out.efci = 1'b0;
  assign cell_out.vc = s.tx_cfg.vc;

  assign fr_out_valid = (s.rx_st == fr_atm_iwf_pkg::RX_PLAY);
  assign fr_out.data = s.obyte;
  assign fr_out.last = (s.oidx + 16'h0001 == s.rlen);
  assign fr_out.conn = s.rx_conn;

  // Reassembly store, written in order, read back for playout
  assign mem_we = rx_acc && (s.wcnt < MAX_LEN);
  assign rd_idx = (s.rx_st == fr_atm_iwf_pkg::RX_PLAY) ?
                  s.oidx + 16'h0001 : 16'h0000;
  assign rd_raw = rx_mem[rd_idx[AW-1:0]];
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      rx_mem[s.wcnt[AW-1:0]] <= cell_in.data;
    end
  end

  // All next-state logic
  always_comb begin
    logic [fr_atm_iwf_pkg::CONN_W:0] dec;
    logic [31:0] merged;
    logic [31:0] crc_n;
    logic [63:0] sh_n;
    logic [16:0] total;
    logic [16:0] len17;
    logic shape_ok;
    logic [fr_atm_iwf_pkg::CONN_W-1:0] hidx;
    logic [5:0] pos_n;
    logic [31:0] fc;
    dec = '0;
    merged = '0;
    crc_n = '0;
    sh_n = '0;
    total = '0;
    len17 = '0;
    shape_ok = 1'b0;
    hidx = '0;
    pos_n = '0;
    fc = '0;
    rx_crc_ok = 1'b0;
    rx_hit = 1'b0;
    next_s = s;
    // Bus slave: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      dec = conn_decode(s.awaddr);
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = fr_atm_iwf_pkg::RESP_OKAY;
      if (dec[fr_atm_iwf_pkg::CONN_W]) begin
        merged = 32'(s.cfg[dec[fr_atm_iwf_pkg::CONN_W-1:0]]);
        for (int b = 0; b < 4; b++) begin
          if (s.wstrb[b]) begin
            merged[8*b +: 8] = s.wdata[8*b +: 8];
          end
        end
        next_s.cfg[dec[fr_atm_iwf_pkg::CONN_W-1:0]] =
          merged[fr_atm_iwf_pkg::CFG_W-1:0];
      end else if (s.awaddr > fr_atm_iwf_pkg::REG_RX_DROP) begin
        next_s.bresp = fr_atm_iwf_pkg::RESP_DECERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      dec = conn_decode(s_axi_araddr);
      next_s.rvalid = 1'b1;
      next_s.rresp = fr_atm_iwf_pkg::RESP_OKAY;
      next_s.rdata = '0;
      case (s_axi_araddr)
        fr_atm_iwf_pkg::REG_TX_FRAMES: next_s.rdata = 32'(s.tx_frames);
        fr_atm_iwf_pkg::REG_RX_FRAMES: next_s.rdata = 32'(s.rx_frames);
        fr_atm_iwf_pkg::REG_RX_CRC_ERR: next_s.rdata = 32'(s.crc_err);
        fr_atm_iwf_pkg::REG_RX_DROP: next_s.rdata = 32'(s.drops);
        default: begin
          if (dec[fr_atm_iwf_pkg::CONN_W]) begin
            next_s.rdata = 32'(s.cfg[dec[fr_atm_iwf_pkg::CONN_W-1:0]]);
          end else begin
            next_s.rresp = fr_atm_iwf_pkg::RESP_DECERR;
          end
        end
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Segmentation side
    case (s.tx_st)
      fr_atm_iwf_pkg::TX_DATA: begin
        if (tx_acc) begin
          // Connection setup latched per frame
          if (s.in_cnt == 2'h0) begin
            next_s.tx_cfg = s.cfg[fr_in.conn];
          end
          if (s.in_cnt == 2'h1) begin
            next_s.tx_de = fr_in.data[fr_atm_iwf_pkg::HDR_DE_BIT];
          end
          if (s.in_cnt != 2'h2) begin
            next_s.in_cnt = s.in_cnt + 2'h1;
          end
          // Header octets, FECN included, pass untouched
          case (s.held)
            2'h0: begin
              next_s.p0 = fr_in.data;
              next_s.held = 2'h1;
            end
            2'h1: begin
              next_s.p1 = fr_in.data;
              next_s.held = 2'h2;
            end
            default: begin
              next_s.p0 = s.p1;
              next_s.p1 = fr_in.data;
              next_s.tx_crc =
                fr_atm_iwf_pkg::crc32_byte(s.tx_crc, s.p0);
              next_s.tx_len = s.tx_len + 16'h0001;
              next_s.pos = pos_inc(s.pos);
            end
          endcase
          if (fr_in.last) begin
            // Two held octets are the FCS and are dropped
            next_s.held = 2'h0;
            next_s.in_cnt = 2'h0;
            next_s.p0 = 8'h00;
            next_s.tidx = 3'h0;
            if (s.held == 2'h2) begin
              next_s.tx_frames = s.tx_frames + 16'h0001;
              next_s.tx_st = (next_s.pos == fr_atm_iwf_pkg::TRAIL_START) ?
                             fr_atm_iwf_pkg::TX_TRAIL :
                             fr_atm_iwf_pkg::TX_PAD;
            end
          end
        end
      end
      fr_atm_iwf_pkg::TX_PAD: begin
        if (cell_out_ready) begin
          next_s.tx_crc = fr_atm_iwf_pkg::crc32_byte(s.tx_crc, 8'h00);
          pos_n = pos_inc(s.pos);
          next_s.pos = pos_n;
          if (pos_n == fr_atm_iwf_pkg::TRAIL_START) begin
            next_s.tx_st = fr_atm_iwf_pkg::TX_TRAIL;
          end
        end
      end
      fr_atm_iwf_pkg::TX_TRAIL: begin
        if (cell_out_ready) begin
          crc_n = (s.tidx < 3'h4) ?
                  fr_atm_iwf_pkg::crc32_byte(s.tx_crc, s.p0) : s.tx_crc;
          fc = ~crc_n;
          next_s.tx_crc = crc_n;
          next_s.pos = pos_inc(s.pos);
          next_s.tidx = s.tidx + 3'h1;
          // Trailer: UU, CPI, length, then inverted CRC
          case (s.tidx)
            3'h1: next_s.p0 = s.tx_len[15:8];
            3'h2: next_s.p0 = s.tx_len[7:0];
            3'h3: next_s.p0 = fc[31:24];
            3'h4: next_s.p0 = fc[23:16];
            3'h5: next_s.p0 = fc[15:8];
            3'h6: next_s.p0 = fc[7:0];
            default: next_s.p0 = 8'h00;
          endcase
          if (s.tidx == 3'h7) begin
            next_s.tx_st = fr_atm_iwf_pkg::TX_DATA;
            next_s.tx_len = '0;
            next_s.tx_crc = fr_atm_iwf_pkg::CRC32_INIT;
          end
        end
      end
      default: next_s.tx_st = fr_atm_iwf_pkg::TX_DATA;
    endcase

    // Reassembly side; one PDU at a time, cells of it arrive in a row
    case (s.rx_st)
      fr_atm_iwf_pkg::RX_RECV: begin
        if (rx_acc) begin
          crc_n = fr_atm_iwf_pkg::crc32_byte(s.rx_crc, cell_in.data);
          sh_n = {s.sh[55:0], cell_in.data};
          total = s.wcnt + 17'h00001;
          next_s.rx_crc = crc_n;
          next_s.sh = sh_n;
          next_s.clp_any = s.clp_any | cell_in.clp;
          if (s.wcnt != '1) begin
            next_s.wcnt = total;
          end
          if (s.wcnt == 17'h0) begin
            next_s.rx_vc = cell_in.vc;
            next_s.hdr0 = cell_in.data;
          end
          if (s.wcnt == 17'h1) begin
            next_s.hdr1 = cell_in.data;
          end
          if (cell_in.cell_end && cell_in.uu) begin
            len17 = {1'b0, sh_n[47:32]};
            rx_crc_ok = (crc_n == fr_atm_iwf_pkg::CRC32_RESIDUE);
            shape_ok = (len17 >= fr_atm_iwf_pkg::HDR_MIN) &&
                       (total <= MAX_LEN) && (sh_n[55:48] == 8'h00) &&
                       (len17 + fr_atm_iwf_pkg::TRAIL_LEN <= total) &&
                       (total - len17 - fr_atm_iwf_pkg::TRAIL_LEN <
                        fr_atm_iwf_pkg::CELL_LEN);
            // Identifier taken from octets 0 and 1 for every length
            for (int i = fr_atm_iwf_pkg::NCONN - 1; i >= 0; i--) begin
              if (s.cfg[i].vc == s.rx_vc && (!s.cfg[i].mux ||
                  s.cfg[i].dlci == {s.hdr0[7:2], s.hdr1[7:4]})) begin
                rx_hit = 1'b1;
                hidx = fr_atm_iwf_pkg::CONN_W'(i);
              end
            end
            next_s.wcnt = '0;
            next_s.rx_crc = fr_atm_iwf_pkg::CRC32_INIT;
            next_s.clp_any = 1'b0;
            if (!rx_crc_ok) begin
              next_s.crc_err = s.crc_err + 16'h0001;
            end else if (!(shape_ok && rx_hit)) begin
              next_s.drops = s.drops + 16'h0001;
            end else begin
              next_s.rx_st = fr_atm_iwf_pkg::RX_PLAY;
              next_s.rx_frames = s.rx_frames + 16'h0001;
              next_s.rx_conn = hidx;
              next_s.rx_ignore = s.cfg[hidx].rx_clp_ignore;
              // Any-CLP taken before its clear, final octet included
              next_s.de_add = (s.clp_any | cell_in.clp) &
                              !s.cfg[hidx].rx_clp_ignore;
              next_s.fecn_add = cell_in.efci;
              next_s.rlen = sh_n[47:32];
              next_s.oidx = 16'h0000;
              next_s.obyte = rd_raw;
            end
            next_s.clp_any = 1'b0;
          end
        end
      end
      fr_atm_iwf_pkg::RX_PLAY: begin
        if (fr_out_ready) begin
          next_s.oidx = s.oidx + 16'h0001;
          // Header bits only ever raised, never cleared
          next_s.obyte = rd_raw;
          if (rd_idx == 16'h0001) begin
            next_s.obyte = rd_raw |
              (s.de_add ? fr_atm_iwf_pkg::HDR_DE_MASK : 8'h00) |
              (s.fecn_add ? fr_atm_iwf_pkg::HDR_FECN_MASK : 8'h00);
          end
          if (s.oidx + 16'h0001 == s.rlen) begin
            next_s.rx_st = fr_atm_iwf_pkg::RX_RECV;
          end
        end
      end
      default: next_s.rx_st = fr_atm_iwf_pkg::RX_RECV;
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= reset_value();
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_efci_zero: assert property (cell_out_valid |-> !cell_out.efci)
    else $error("cell sent with EFCI set");
  a_clp_fixed: assert property (cell_out_valid && s.tx_cfg.tx_clp_const
    |-> cell_out.clp == s.tx_cfg.clp_value)
    else $error("fixed CLP not applied");
  a_de_capture: assert property (tx_acc && s.in_cnt == 2'h1 &&
    !s.tx_cfg.tx_clp_const |=> cell_out.clp ==
    $past(fr_in.data[fr_atm_iwf_pkg::HDR_DE_BIT]))
    else $error("CLP does not follow frame DE");
  a_fcs_strip: assert property (tx_acc && fr_in.last && s.held == 2'h2
    |=> s.tx_st != fr_atm_iwf_pkg::TX_DATA &&
    s.tx_len == $past(s.tx_len) + 16'h0001)
    else $error("FCS octets not stripped");
  a_uu_final: assert property (cell_out_valid && cell_out.uu
    |-> cell_out.cell_end && s.tx_st == fr_atm_iwf_pkg::TX_TRAIL)
    else $error("end mark outside final cell");
  a_trail_align: assert property ($rose(s.tx_st == fr_atm_iwf_pkg::TX_TRAIL)
    |-> s.pos == fr_atm_iwf_pkg::TRAIL_START)
    else $error("trailer not at cell end");
  a_crc_gate: assert property ($rose(s.rx_st == fr_atm_iwf_pkg::RX_PLAY)
    |-> $past(rx_crc_ok) && $past(rx_hit))
    else $error("frame released without good CRC or connection");
  a_de_pass: assert property (fr_out_valid && s.oidx == 16'h0001 &&
    s.rx_ignore |-> fr_out.data[fr_atm_iwf_pkg::HDR_DE_BIT] ==
    s.hdr1[fr_atm_iwf_pkg::HDR_DE_BIT])
    else $error("DE altered in pass mode");
  a_de_raise: assert property (fr_out_valid && s.oidx == 16'h0001 &&
    s.de_add |-> fr_out.data[fr_atm_iwf_pkg::HDR_DE_BIT])
    else $error("DE not raised after CLP");
  a_fecn_map: assert property (fr_out_valid && s.oidx == 16'h0001 |->
    fr_out.data[fr_atm_iwf_pkg::HDR_FECN_BIT] == (s.fecn_add |
    s.hdr1[fr_atm_iwf_pkg::HDR_FECN_BIT]))
    else $error("FECN mapping wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write response dropped");

  c_tx_frame: cover property (cell_out_valid && cell_out_ready &&
    cell_out.uu);
  c_rx_frame: cover property (fr_out_valid && fr_out_ready && fr_out.last);
  c_crc_bad: cover property (rx_acc && cell_in.uu && !rx_crc_ok);
  c_de_raised: cover property ($rose(s.rx_st == fr_atm_iwf_pkg::RX_PLAY)
    && s.de_add);
endmodule : fr_atm_iwf
`default_nettype wire

/* File: verification/cell_loop_model.sv */
// Cell-side partner: loops cells back with stalls and congestion marking
`timescale 1ns/1ps
`default_nettype none
module cell_loop_model (
  // Clock
  input wire logic aclk,
  // Cells from the design
  input wire fr_atm_iwf_pkg::cell_beat_type cell_out,
  input wire logic cell_out_valid,
  output logic cell_out_ready,
  // Cells back to the design
  output fr_atm_iwf_pkg::cell_beat_type cell_in,
  output logic cell_in_valid,
  input wire logic cell_in_ready,
  // Congestion marking
  input wire logic efci_force
);
  logic [1:0] tick = 2'h0;
  logic stall;
  // Stall one cycle in four so back-pressure is always exercised
  always @(posedge aclk) tick <= tick + 2'h1;
  assign stall = (tick == 2'h3);
  // Pass-through keeps the final-cell mark and channel
  assign cell_out_ready = cell_in_ready && !stall;
  assign cell_in_valid = cell_out_valid && !stall;
  always_comb begin
    cell_in = cell_out;
    cell_in.efci = efci_force; // Congested network
    // Idle beats show inverted data, never a stale copy
    if (!cell_in_valid) cell_in.data = ~cell_out.data;
  end
endmodule : cell_loop_model
`default_nettype wire

/* File: verification/fr_atm_interworking_mapping_bench.sv */
// Bench: frames looped through cells, mapping modes and counters
`timescale 1ns/1ps
`default_nettype none
module fr_atm_interworking_mapping_bench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, fr_in_valid = 0;
  logic fr_out_ready = 0, efci_force = 0, exp_clp = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, fr_in_ready, cell_out_valid, cell_out_ready;
  logic cell_in_valid, cell_in_ready, fr_out_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  fr_atm_iwf_pkg::frame_beat_type fr_in = '0, fr_out;
  fr_atm_iwf_pkg::cell_beat_type cell_out, cell_in;
  int err_total = 0, checks = 0, beats = 0;
  always #12.5 aclk = ~aclk;
  // Frame sink stalls every other cycle
  always @(posedge aclk) fr_out_ready <= ~fr_out_ready;
  fr_atm_iwf #(.MAX_PDU(128)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .fr_in(fr_in), .fr_in_valid(fr_in_valid),
    .fr_in_ready(fr_in_ready), .cell_out(cell_out),
    .cell_out_valid(cell_out_valid), .cell_out_ready(cell_out_ready),
    .cell_in(cell_in), .cell_in_valid(cell_in_valid),
    .cell_in_ready(cell_in_ready), .fr_out(fr_out),
    .fr_out_valid(fr_out_valid), .fr_out_ready(fr_out_ready));
  cell_loop_model far (.aclk(aclk), .cell_out(cell_out),
    .cell_out_valid(cell_out_valid), .cell_out_ready(cell_out_ready),
    .cell_in(cell_in), .cell_in_valid(cell_in_valid),
    .cell_in_ready(cell_in_ready), .efci_force(efci_force));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Cell monitor: loss priority, congestion and framing per beat
  always @(posedge aclk) if (cell_out_valid && cell_out_ready) begin
    chk("cell efci", 0, cell_out.efci);
    chk("cell clp", exp_clp, cell_out.clp);
    chk("cell vc", 0, cell_out.vc);
    chk("uu beat", beats == 47, cell_out.uu);
    chk("cell end", beats == 47, cell_out.cell_end);
    beats++;
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : axi_rd
  // One frame out and back; cfg, DE, FECN, EFCI, then expectations
  task automatic run(input logic [15:0] c,
                     input logic de, fe, ef, ec, ed, eo);
    logic [7:0] f [6];
    logic [7:0] x [4];
    int n;
    f = '{8'h18, 8'h41 | {4'h0, fe, 1'b0, de, 1'b0}, 8'hA5, 8'h5A, 8'hC3, 8'h3C};
    x = '{8'h18, 8'h41 | {4'h0, eo, 1'b0, ed, 1'b0}, 8'hA5, 8'h5A};
    axi_wr(fr_atm_iwf_pkg::REG_CONN_BASE, {16'h0, c});
    chk("bresp", fr_atm_iwf_pkg::RESP_OKAY, rr);
    exp_clp = ec;
    beats = 0;
    efci_force <= ef;
    fork
      begin
        for (int i = 0; i < 6; i++) begin
          fr_in <= {f[i], i == 5, 2'h0};
          fr_in_valid <= 1;
          do @(posedge aclk); while (!fr_in_ready);
        end
        fr_in_valid <= 0;
      end
      for (n = 0; n < 4; ) begin
        @(posedge aclk);
        if (fr_out_valid && fr_out_ready) begin
          chk("octet", x[n], fr_out.data);
          chk("last", n == 3, fr_out.last);
          chk("conn", 0, fr_out.conn);
          n++;
        end
      end
    join
    chk("cells", 48, beats);
    $display("test cfg %h done", c);
  endtask : run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    #500000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    axi_rd(8'h14);
    chk("conn1 reset", 32'h00004000, rd);
    axi_rd(8'h40);
    chk("unmapped", fr_atm_iwf_pkg::RESP_DECERR, rr);
    run(4'h0, 1, 0, 0, 1, 1, 0);
    run(4'h1, 1, 0, 0, 0, 1, 0);
    run(4'h3, 0, 0, 0, 1, 1, 0);
    run(4'h7, 0, 0, 0, 1, 0, 0);
    run(4'h0, 0, 0, 1, 0, 0, 1);
    run(4'h0, 0, 1, 0, 0, 0, 1);
    // Shared channel: header identifier 0x64 must match the setup
    run(16'h0648, 0, 0, 0, 0, 0, 0);
    axi_rd(fr_atm_iwf_pkg::REG_TX_FRAMES);
    chk("tx frames", 7, rd);
    axi_rd(fr_atm_iwf_pkg::REG_RX_DROP);
    chk("drops", 0, rd);
    axi_rd(fr_atm_iwf_pkg::REG_RX_CRC_ERR);
    chk("crc errors", 0, rd);
    axi_rd(fr_atm_iwf_pkg::REG_RX_FRAMES);
    chk("rx frames", 7, rd);
    stop_test();
  end
endmodule : fr_atm_interworking_mapping_bench
`default_nettype wire
